// File: psd_datapath.sv
`timescale 1ns/1ps
`include "psd_defines.svh"

// Summary of operation
// RULE_01: eight 64-bit packed registers serve as operands and destinations.
// RULE_02: registers hold the exact memory image of a 64-bit quantity.
// RULE_03: full-width mode covers 64-bit loads, stores, moves, pack, logic, arithmetic; no pack operation is implemented here.
// RULE_04: half-width mode covers 32-bit loads, stores and general register moves.
// RULE_05: packed registers share storage with the floating-point stack registers.
// RULE_06: a 64-bit operand splits into eight bytes, four words or two doublewords.
// RULE_07: moves copy whole 64 bits; arithmetic computes each lane independently.
// RULE_08: stored elements go lowest first at lowest address, bytes little endian.
// RULE_09: signed saturating word add combines four 16-bit lanes into four results.
// RULE_10: wraparound keeps only the low bits of an out-of-range lane.
// RULE_11: signed saturation clamps to the signed range, bytes 80H to 7FH.
// RULE_12: signed word saturation gives 7FFFH high and 8000H low.
// RULE_13: unsigned saturation gives FFH or FFFFH high and zero low.
// RULE_14: no operation ever raises an exception or touches the status flags.
// RULE_15: the issuer supplies element size and overflow handling with every operation.
module psd_datapath #(
  parameter int NUM_REGS = `PSD_NUM_REGS,
  parameter int REG_W    = `PSD_REG_W
) (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  // issue from the decode pipeline
  input  wire psd_pkg::psd_issue_t    issue_i,
  // floating-point view of the shared storage
  input  wire psd_pkg::psd_fp_wr_t    fp_wr_i,
  input  wire logic [2:0]             fp_rd_idx_i,
  output logic      [63:0]            fp_rd_data_o,
  // result to the pipeline and memory store path
  output psd_pkg::psd_result_t        result_o,
  output logic      [7:0][7:0]        store_bytes_o,
  output logic                        store_half_o
);

  // the lane engine and storage are built for exactly this geometry
  if (NUM_REGS != `PSD_NUM_REGS || REG_W != `PSD_REG_W) begin : g_geom_check
    $error("psd_datapath supports only eight 64-bit registers");
  end

  // shared storage: index i is packed_reg_i and also floating-point stack entry i,
  // from fpu_stack_entry_first at 0 up to fpu_stack_entry_last at 7
  logic [`PSD_REG_W-1:0] regs_q [`PSD_NUM_REGS]; // [RULE_01] [RULE_05]
  logic [`PSD_REG_W-1:0] regs_d [`PSD_NUM_REGS];

  psd_pkg::psd_result_t  result_q;
  psd_pkg::psd_result_t  result_d;
  logic [7:0][7:0]       store_q;
  logic [7:0][7:0]       store_d;
  logic                  half_q;
  logic                  half_d;
  logic [63:0]           fp_rd_q;
  logic [63:0]           fp_rd_d;

  logic [63:0]           opnd_a;
  logic [63:0]           opnd_b;
  logic [63:0]           alu_y;
  logic [63:0]           wr_val;
  logic                  wr_en;

  // operand fetch; the second operand may come from memory or a general register
  always_comb begin
    opnd_a = regs_q[issue_i.src_a];
    opnd_b = issue_i.b_ext ? issue_i.ext_data : regs_q[issue_i.src_b];
  end

  psd_lane_alu u_alu (
    .op_i   (issue_i.op),
    .elem_i (issue_i.elem),
    .ovf_i  (issue_i.ovf),   // selects come with each op from the issuer [RULE_15]
    .a_i    (opnd_a),
    .b_i    (opnd_b),
    .y_o    (alu_y)
  );

  // choose the value to write back and its access width
  always_comb begin
    wr_en  = issue_i.valid;
    wr_val = alu_y;                                           // [RULE_03]
    half_d = 1'b0;
    case (issue_i.op)
      psd_pkg::PSD_OP_NOP:  wr_en = 1'b0;
      psd_pkg::PSD_OP_MOVQ: wr_val = opnd_b;                  // whole block moved [RULE_03] [RULE_07]
      psd_pkg::PSD_OP_MOVD: begin
        // 32-bit move: low half carried, upper half cleared [RULE_04]
        wr_val = {32'h00000000, opnd_b[`PSD_HALF_W-1:0]};
        half_d = 1'b1;
      end
      default: wr_val = alu_y;
    endcase
  end

  // next state of storage; a packed write wins over a same-cycle stack write
  // to the same entry, since the pipeline orders them and the later one is ours
  always_comb begin
    for (int i = 0; i < `PSD_NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
      if (fp_wr_i.we && fp_wr_i.idx == i[2:0]) regs_d[i] = fp_wr_i.data;    // [RULE_05]
      if (wr_en && issue_i.dst == i[2:0]) regs_d[i] = wr_val;               // [RULE_02]
    end
  end

  // outputs: result, memory image and stack view readback
  always_comb begin
    result_d.valid = wr_en;
    result_d.dst   = issue_i.dst;
    result_d.data  = wr_val;
    // byte k of the store is memory address base+k, least significant first [RULE_08]
    for (int k = 0; k < 8; k++) begin
      store_d[k] = wr_val[k*8 +: 8];
    end
    // the stack view sees the same bits as the packed view, no reformatting [RULE_05]
    fp_rd_d = regs_d[fp_rd_idx_i];
    // no flag or exception outputs exist: overflow is absorbed in the lanes [RULE_14]
  end

  // registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `PSD_NUM_REGS; i++) begin
        regs_q[i] <= `PSD_REG_RST;
      end
      result_q <= '0;
      store_q  <= '0;
      half_q   <= 1'b0;
      fp_rd_q  <= `PSD_REG_RST;
    end else begin
      for (int i = 0; i < `PSD_NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
      result_q <= result_d;
      store_q  <= store_d;
      half_q   <= half_d;
      fp_rd_q  <= fp_rd_d;
    end
  end

  assign result_o      = result_q;
  assign store_bytes_o = store_q;
  assign store_half_o  = half_q;
  assign fp_rd_data_o  = fp_rd_q;

endmodule : psd_datapath

// File: psd_datapath_properties.sv
`timescale 1ns/1ps
// port-level checks of the packed datapath
module psd_chk #(
  parameter int NUM_REGS = 8,
  parameter int REG_W    = 64
) (
  // clock and reset
  input wire logic                 core_clk_i,
  input wire logic                 rst_n_i,
  // inputs of the datapath
  input wire psd_pkg::psd_issue_t  issue_i,
  input wire psd_pkg::psd_fp_wr_t  fp_wr_i,
  input wire logic [2:0]           fp_rd_idx_i,
  // outputs of the datapath
  input wire logic [63:0]          fp_rd_data_o,
  input wire psd_pkg::psd_result_t result_o,
  input wire logic [7:0][7:0]      store_bytes_o,
  input wire logic                 store_half_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // decoded views of the issue; a no-op writes nothing
  wire logic        take    = issue_i.valid && (issue_i.op != psd_pkg::PSD_OP_NOP);
  wire logic        is_movd = issue_i.op == psd_pkg::PSD_OP_MOVD;
  wire logic        movq_x  = take && issue_i.op == psd_pkg::PSD_OP_MOVQ && issue_i.b_ext;
  wire logic [31:0] ext_lo  = issue_i.ext_data[31:0];
  // a packed write to the same entry wins, so such cycles are left out
  wire logic        fp_only = fp_wr_i.we && fp_wr_i.idx == fp_rd_idx_i &&
                              !(take && issue_i.dst == fp_wr_i.idx);

  a_result_on_take: assert property (take |=> result_o.valid &&
    result_o.dst == $past(issue_i.dst)) else $error("result missing or misdirected");
  a_no_idle_result: assert property (!take |=> !result_o.valid)
    else $error("result without an issue");
  a_movq_whole: assert property (movq_x |=> result_o.data == $past(issue_i.ext_data))
    else $error("quadword move altered data");
  a_movd_low_half: assert property (take && is_movd && issue_i.b_ext |=>
    result_o.data == {32'h0, $past(ext_lo)}) else $error("doubleword move wrong");
  a_half_flag_match: assert property (take |=> store_half_o == $past(is_movd))
    else $error("access width flag wrong");
  a_store_little_end: assert property (result_o.valid |-> store_bytes_o == result_o.data)
    else $error("store byte order wrong");
  a_fp_write_seen: assert property (fp_only |=> fp_rd_data_o == $past(fp_wr_i.data))
    else $error("stack write not visible");
  a_packed_alias: assert property (take && issue_i.dst == fp_rd_idx_i |=>
    fp_rd_data_o == result_o.data) else $error("packed write not visible in stack");
  // main scenarios
  c_ssat: cover property (take && issue_i.ovf == psd_pkg::PSD_OVF_SSAT);
  c_fp_wr: cover property (fp_only);
  c_movd: cover property (take && is_movd);
  c_alias: cover property (take && issue_i.dst == fp_rd_idx_i);
endmodule : psd_chk

bind psd_datapath psd_chk #(.NUM_REGS(NUM_REGS), .REG_W(REG_W)) i_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i), .fp_wr_i(fp_wr_i),
  .fp_rd_idx_i(fp_rd_idx_i), .fp_rd_data_o(fp_rd_data_o), .result_o(result_o),
  .store_bytes_o(store_bytes_o), .store_half_o(store_half_o));

// File: psd_decode_model.sv
`timescale 1ns/1ps
// decode-side model: one issue per call, held for one cycle
module psd_decode_model (
  // clock
  input  wire logic          core_clk_i,
  // issue to the datapath
  output psd_pkg::psd_issue_t issue_o
);
  initial issue_o = '0;

  // every issue carries element size and overflow handling
  task automatic send(input psd_pkg::psd_op_t op, input psd_pkg::psd_elem_t el,
                      input psd_pkg::psd_ovf_t ov, input logic [2:0] dst,
                      input logic [2:0] sa, input logic [2:0] sb,
                      input logic bx, input logic [63:0] xd);
    psd_pkg::psd_issue_t t;
    t = '{1'b1, op, el, ov, dst, sa, sb, bx, xd};
    @(posedge core_clk_i);
    issue_o <= t;
    @(posedge core_clk_i);
    t = ~t;  // stale payload is scrambled so it cannot be mistaken for a request
    t.valid = 1'b0;
    issue_o <= t;
  endtask : send
endmodule : psd_decode_model

// File: psd_defines.svh
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH

// register file geometry
`define PSD_NUM_REGS      8
`define PSD_REG_W         64
`define PSD_IDX_W         3
`define PSD_HALF_W        32

// element sizes in bits
`define PSD_BYTE_W        8
`define PSD_WORD_W        16
`define PSD_DWORD_W       32

// saturation limits
`define PSD_SB_MAX        8'h7F
`define PSD_SB_MIN        8'h80
`define PSD_SW_MAX        16'h7FFF
`define PSD_SW_MIN        16'h8000
`define PSD_SD_MAX        32'h7FFFFFFF
`define PSD_SD_MIN        32'h80000000
`define PSD_UB_MAX        8'hFF
`define PSD_UW_MAX        16'hFFFF
`define PSD_UD_MAX        32'hFFFFFFFF

// reset value of every storage entry
`define PSD_REG_RST       64'h0000000000000000

`endif

// File: psd_lane_alu.sv
`timescale 1ns/1ps
`include "psd_defines.svh"

// combinational lane engine: every lane computed independently
module psd_lane_alu (
  // operation
  input  wire psd_pkg::psd_op_t   op_i,
  input  wire psd_pkg::psd_elem_t elem_i,
  input  wire psd_pkg::psd_ovf_t  ovf_i,
  // operands
  input  wire logic [63:0]        a_i,
  input  wire logic [63:0]        b_i,
  // result
  output logic      [63:0]        y_o
);

  // clamp a w+1 bit true sum/difference to w bits
  function automatic logic [31:0] clamp(input logic [32:0] r, input logic [2:0] c,
                                        input int w, input psd_pkg::psd_ovf_t m);
    logic [31:0] smax;
    logic [31:0] smin;
    logic [31:0] umax;
    logic        sovf_p;
    logic        sovf_n;
    smax = (w == `PSD_BYTE_W) ? 32'(`PSD_SB_MAX) :
           (w == `PSD_WORD_W) ? 32'(`PSD_SW_MAX) : `PSD_SD_MAX;
    smin = (w == `PSD_BYTE_W) ? 32'(`PSD_SB_MIN) :
           (w == `PSD_WORD_W) ? 32'(`PSD_SW_MIN) : `PSD_SD_MIN;
    umax = (w == `PSD_BYTE_W) ? 32'(`PSD_UB_MAX) :
           (w == `PSD_WORD_W) ? 32'(`PSD_UW_MAX) : `PSD_UD_MAX;
    // signed overflow: sign bit w differs from bit w-1 of the extended result
    sovf_p = !r[w] && r[w-1];
    sovf_n = r[w] && !r[w-1];
    clamp  = r[31:0] & umax;                              // [RULE_10]
    case (m)
      psd_pkg::PSD_OVF_SSAT: begin
        if (sovf_p && r[32] == 1'b0 && c[0]) clamp = smax;  // [RULE_11] [RULE_12]
        if (sovf_n && c[0]) clamp = smin;                   // [RULE_11] [RULE_12]
      end
      psd_pkg::PSD_OVF_USAT: begin
        if (c[1]) clamp = umax;                             // [RULE_13]
        if (c[2]) clamp = 32'h00000000;                     // [RULE_13]
      end
      default: clamp = r[31:0] & umax;
    endcase
  endfunction : clamp

  // one lane of add/sub/logic/compare at width w, returned in the low w bits
  function automatic logic [31:0] lane(input logic [31:0] a, input logic [31:0] b, input int w,
                                       input psd_pkg::psd_op_t o, input psd_pkg::psd_ovf_t m);
    logic [32:0] sa;
    logic [32:0] sb;
    logic [32:0] r;
    logic [32:0] ua;
    logic [32:0] ub;
    logic [32:0] ur;
    logic [31:0] msk;
    logic        sov;
    msk  = (w == `PSD_DWORD_W) ? `PSD_UD_MAX : ((32'h00000001 << w) - 32'h00000001);
    ua   = {1'b0, a & msk};
    ub   = {1'b0, b & msk};
    // sign-extend each lane to 33 bits
    sa   = ua;
    sb   = ub;
    if (a[w-1]) sa = ua | ~{1'b0, msk};
    if (b[w-1]) sb = ub | ~{1'b0, msk};
    lane = 32'h00000000;
    case (o)
      psd_pkg::PSD_OP_ADD, psd_pkg::PSD_OP_SUB: begin
        r  = (o == psd_pkg::PSD_OP_ADD) ? sa + sb : sa - sb;   // [RULE_09]
        ur = (o == psd_pkg::PSD_OP_ADD) ? ua + ub : ua - ub;
        sov = (r[w] != r[w-1]);
        // all 33 bits go on: a doubleword lane's sign lives in bit 32
        lane = clamp(r, {(o == psd_pkg::PSD_OP_SUB) && ur[32],
                                        (o == psd_pkg::PSD_OP_ADD) && ur[w], sov},
                     w, m);
      end
      psd_pkg::PSD_OP_AND:   lane = a & b;
      psd_pkg::PSD_OP_ANDN:  lane = ~a & b;
      psd_pkg::PSD_OP_OR:    lane = a | b;
      psd_pkg::PSD_OP_XOR:   lane = a ^ b;
      psd_pkg::PSD_OP_CMPEQ: lane = (ua == ub) ? msk : 32'h00000000;
      psd_pkg::PSD_OP_CMPGT: lane = ($signed(sa) > $signed(sb)) ? msk : 32'h00000000;
      default:               lane = 32'h00000000;
    endcase
    lane = lane & msk;
  endfunction : lane

  // lanes are sliced by element size and evaluated in parallel
  always_comb begin
    y_o = `PSD_REG_RST;
    case (elem_i)
      psd_pkg::PSD_ELEM_BYTE: begin
        for (int i = 0; i < 8; i++) begin
          y_o[i*8 +: 8] = 8'(lane({24'h000000, a_i[i*8 +: 8]}, {24'h000000, b_i[i*8 +: 8]},
                                  `PSD_BYTE_W, op_i, ovf_i)); // [RULE_06] [RULE_07]
        end
      end
      psd_pkg::PSD_ELEM_WORD: begin
        for (int i = 0; i < 4; i++) begin
          y_o[i*16 +: 16] = 16'(lane({16'h0000, a_i[i*16 +: 16]}, {16'h0000, b_i[i*16 +: 16]},
                                     `PSD_WORD_W, op_i, ovf_i)); // [RULE_06] [RULE_09]
        end
      end
      default: begin
        for (int i = 0; i < 2; i++) begin
          y_o[i*32 +: 32] = lane(a_i[i*32 +: 32], b_i[i*32 +: 32],
                                 `PSD_DWORD_W, op_i, ovf_i); // [RULE_06]
        end
      end
    endcase
  end

endmodule : psd_lane_alu

// File: psd_pkg.sv
package psd_pkg;

  // element size select
  typedef enum logic [1:0] {
    PSD_ELEM_BYTE,
    PSD_ELEM_WORD,
    PSD_ELEM_DWORD,
    PSD_ELEM_QWORD
  } psd_elem_t;

  // out-of-range handling select
  typedef enum logic [1:0] {
    PSD_OVF_WRAP,
    PSD_OVF_SSAT,
    PSD_OVF_USAT
  } psd_ovf_t;

  // operation select
  typedef enum logic [3:0] {
    PSD_OP_NOP,
    PSD_OP_MOVQ,
    PSD_OP_MOVD,
    PSD_OP_ADD,
    PSD_OP_SUB,
    PSD_OP_AND,
    PSD_OP_ANDN,
    PSD_OP_OR,
    PSD_OP_XOR,
    PSD_OP_CMPEQ,
    PSD_OP_CMPGT
  } psd_op_t;

  // one issued operation
  typedef struct packed {
    logic       valid;
    psd_op_t    op;
    psd_elem_t  elem;
    psd_ovf_t   ovf;
    logic [2:0] dst;
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic       b_ext;
    logic [63:0] ext_data;
  } psd_issue_t;

  // result returned to the pipeline
  typedef struct packed {
    logic        valid;
    logic [2:0]  dst;
    logic [63:0] data;
  } psd_result_t;

  // floating-point view write port
  typedef struct packed {
    logic        we;
    logic [2:0]  idx;
    logic [63:0] data;
  } psd_fp_wr_t;

endpackage : psd_pkg

// File: testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module testbench;
  logic                 core_clk_i = 1'b0;
  logic                 rst_n_i    = 1'b0;
  psd_pkg::psd_fp_wr_t  fp_wr_i    = '0;
  logic [2:0]           fp_rd_idx_i = 3'h0;
  psd_pkg::psd_issue_t  issue_i;
  logic [63:0]          fp_rd_data_o;
  psd_pkg::psd_result_t result_o;
  logic [7:0][7:0]      store_bytes_o;
  logic                 store_half_o;
  int                   n_fail = 0;
  int                   total_checks = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  psd_datapath i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i),
    .fp_wr_i(fp_wr_i), .fp_rd_idx_i(fp_rd_idx_i), .fp_rd_data_o(fp_rd_data_o),
    .result_o(result_o), .store_bytes_o(store_bytes_o), .store_half_o(store_half_o));
  psd_decode_model i_dec (.core_clk_i(core_clk_i), .issue_o(issue_i));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // stack-view read: index driven at one edge, data settled after the next
  task automatic rd(input logic [2:0] idx, input logic [63:0] e);
    @(posedge core_clk_i);
    fp_rd_idx_i <= idx;
    @(posedge core_clk_i);
    #1;
    `CHK(fp_rd_data_o, e)
  endtask : rd

  task automatic ld(input logic [2:0] r, input logic [63:0] v);
    i_dec.send(psd_pkg::PSD_OP_MOVQ, psd_pkg::PSD_ELEM_QWORD, psd_pkg::PSD_OVF_WRAP,
               r, 3'h0, 3'h0, 1'b1, v);
    #1;
  endtask : ld

  task automatic t_load;
    logic [63:0] v;
    for (int r = 0; r < 8; r++) begin
      v = 64'h0706050403020100 + 64'h1010101010101010 * r;
      ld(r[2:0], v);
      `CHK(result_o.data, v)
      for (int k = 0; k < 8; k++) `CHK(store_bytes_o[k], v[8*k +: 8])
      rd(r[2:0], v);
    end
    @(posedge core_clk_i);
    fp_wr_i     <= '{1'b1, 3'h5, 64'hC0DE0000FACE1234};
    fp_rd_idx_i <= 3'h5;  // read back the entry in the cycle it is written
    @(posedge core_clk_i);
    fp_wr_i <= '{1'b0, 3'h2, 64'h3F21FFFF0531EDCB};  // released payload inverted
    #1;
    `CHK(fp_rd_data_o, 64'hC0DE0000FACE1234)
    i_dec.send(psd_pkg::PSD_OP_AND, psd_pkg::PSD_ELEM_QWORD, psd_pkg::PSD_OVF_WRAP,
               3'h6, 3'h5, 3'h0, 1'b1, 64'hFFFF0000FFFF00FF);
    #1;
    `CHK(result_o.data, 64'hC0DE0000FACE0034)
    $display("load and alias test done");
  endtask : t_load

  task automatic ar(input psd_pkg::psd_op_t op, input psd_pkg::psd_elem_t el,
                    input psd_pkg::psd_ovf_t ov, input logic [63:0] a, b, e);
    ld(3'h1, a);
    ld(3'h2, b);
    i_dec.send(op, el, ov, 3'h3, 3'h1, 3'h2, 1'b0, 64'h0);
    #1;
    `CHK(result_o.data, e)
    `CHK(store_half_o, 1'b0)
  endtask : ar

  task automatic t_arith;
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_WORD, psd_pkg::PSD_OVF_SSAT, 64'h7FFF800000011234,
       64'h0001FFFF00020001, 64'h7FFF800000031235);
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_BYTE, psd_pkg::PSD_OVF_SSAT, 64'h7F80000000000000,
       64'h01FF000000000000, 64'h7F80000000000000);
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_BYTE, psd_pkg::PSD_OVF_WRAP, 64'h7F80000000000000,
       64'h01FF000000000000, 64'h807F000000000000);
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_BYTE, psd_pkg::PSD_OVF_USAT, 64'h00FF,
       64'h0101, 64'h01FF);
    ar(psd_pkg::PSD_OP_SUB, psd_pkg::PSD_ELEM_BYTE, psd_pkg::PSD_OVF_USAT, 64'h00FF,
       64'h0101, 64'h00FE);
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_WORD, psd_pkg::PSD_OVF_USAT, 64'h0001FFFF,
       64'h00010001, 64'h0002FFFF);
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_DWORD, psd_pkg::PSD_OVF_WRAP, '1,
       64'h0000000100000001, 64'h0);
    ar(psd_pkg::PSD_OP_XOR, psd_pkg::PSD_ELEM_QWORD, psd_pkg::PSD_OVF_SSAT, 64'hF0F0,
       64'hFF00, 64'h0FF0);
    ar(psd_pkg::PSD_OP_SUB, psd_pkg::PSD_ELEM_WORD, psd_pkg::PSD_OVF_SSAT, 64'h80007FFF,
       64'h0001FFFF, 64'h80007FFF);
    ar(psd_pkg::PSD_OP_ADD, psd_pkg::PSD_ELEM_DWORD, psd_pkg::PSD_OVF_SSAT,
       64'h800000007FFFFFFF, 64'hFFFFFFFF00000001, 64'h800000007FFFFFFF);
    ar(psd_pkg::PSD_OP_CMPEQ, psd_pkg::PSD_ELEM_WORD, psd_pkg::PSD_OVF_WRAP, 64'h12345678,
       64'h12340000, 64'hFFFFFFFFFFFF0000);
    ar(psd_pkg::PSD_OP_CMPGT, psd_pkg::PSD_ELEM_BYTE, psd_pkg::PSD_OVF_WRAP, 64'h017F,
       64'h0180, 64'h00FF);
    ar(psd_pkg::PSD_OP_ANDN, psd_pkg::PSD_ELEM_QWORD, psd_pkg::PSD_OVF_WRAP, 64'hFF00,
       64'h0FF0, 64'h00F0);
    ar(psd_pkg::PSD_OP_OR, psd_pkg::PSD_ELEM_QWORD, psd_pkg::PSD_OVF_WRAP, 64'hF000,
       64'h000F, 64'hF00F);
    $display("arithmetic test done");
  endtask : t_arith

  task automatic t_movd;
    @(posedge core_clk_i);
    fp_rd_idx_i <= 3'h4;  // stack view watches the destination of the move
    i_dec.send(psd_pkg::PSD_OP_MOVD, psd_pkg::PSD_ELEM_DWORD, psd_pkg::PSD_OVF_WRAP,
               3'h4, 3'h0, 3'h0, 1'b1, 64'hAAAA555512345678);
    #1;
    `CHK(result_o.data, 64'h0000000012345678)
    `CHK(fp_rd_data_o, 64'h0000000012345678)
    `CHK(store_half_o, 1'b1)
    $display("half-width move test done");
  endtask : t_movd

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(3'h7, 64'h0);
    t_load();
    t_arith();
    t_movd();
    tally_and_finish();
  end

  // watchdog sized well above the roughly 140 cycles the tests need
  initial begin
    #25000;
    n_fail++;
    tally_and_finish();
  end
endmodule : testbench
